// ---- dv/e2_oh_far_end.sv ----
// Far-end model that inserts the E2 byte over the serial overhead port.
`timescale 1ns/10ps
module e2_oh_far_end #(
	parameter int WAIT_PERIODS = 3   // wait-state length in port periods
) (
	input  wire logic       pclk,    // overhead port clock
	input  wire logic       strobe,  // slot strobe
	input  wire logic       marker,  // frame marker
	input  wire logic [7:0] byte_in, // byte to insert
	output logic            sin      // serial data to device
);
	initial begin
		sin = 1'b0;
		forever begin
			@(posedge pclk);
			if (marker && !strobe) begin
				// parameterised wait, start on a fall.
				repeat (WAIT_PERIODS) @(posedge pclk);
				for (int i = 7; i >= 0; i--) begin
					@(negedge pclk);
					sin <= byte_in[i];
				end
				// The released line shows the inverse, so a stale bit can never pass.
				@(negedge pclk);
				sin <= ~sin;
			end
		end
	end
endmodule : e2_oh_far_end

// ---- dv/tb_e2_tx_block.sv ----
// Self-checking bench for the E2 transmit block.
`timescale 1ns/10ps
`include "e2_tx_defs.svh"
module tb_e2_tx_block;
	import e2_tx_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, run = 1'b0;
	logic [15:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, rd;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, o_valid, o_sof, pclk, strobe, marker, sin;
	logic [1:0]  bresp, rresp, rs;
	logic [7:0]  in_data = '0, o_data, far_byte = 8'hA6, c0;
	logic        in_valid = 1'b0, in_sof = 1'b0, ins_req = 1'b0;
	logic [3:0]  wstrb = 4'hF;
	logic [2:0]  ost;
	logic [11:0] idx = '0, oi = '0;
	logic [7:0]  obuf [4096];
	int          frames = 0, error_cnt = 0, n_compared = 0, strobe_rises = 0, s0;

	e2_tx_block i_e2_tx_block (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_in_data(in_data), .tx_in_valid(in_valid), .tx_in_sof(in_sof),
		.tx_out_data(o_data), .tx_out_valid(o_valid), .tx_out_sof(o_sof),
		.overhead_port_clock(pclk), .overhead_slot_strobe(strobe),
		.overhead_frame_marker(marker), .overhead_serial_in(sin),
		.overhead_insert_request(ins_req), .oh_state(ost));
	e2_oh_far_end #(.WAIT_PERIODS(`OH_WAIT_PERIODS)) i_e2_oh_far_end (.pclk(pclk),
		.strobe(strobe), .marker(marker), .byte_in(far_byte), .sin(sin));

	initial begin
		forever #4 clk = ~clk;
	end
	// --------
	// Stream source and frame capture
	// --------
	always @(posedge clk) begin
		if (run) begin
			in_valid <= 1'b1;
			in_sof   <= (idx == 12'h000);
			in_data  <= idx[7:0];
			idx      <= idx + 12'h001;
		end
	end
	// Sampled on the falling edge so the registered outputs have settled.
	always @(negedge clk) begin
		if (o_valid === 1'b1) begin
			oi = (o_sof === 1'b1) ? 12'h000 : oi + 12'h001;
			obuf[oi] = o_data;
			if (oi == 12'hFFF)
				frames++;
		end
	end
	// Port rises that find the slot strobe high, one for each E2 bit.
	always @(posedge pclk) begin
		if (strobe === 1'b1)
			strobe_rises++;
	end
	// --------
	// Shared tasks
	// --------
	task automatic summarize;
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, tw, dn;
		ta = 1'b0;
		tw = 1'b0;
		dn = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!dn && n < 64) begin
			@(negedge clk);
			ta = ta | awready;
			tw = tw | wready;
			dn = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			n++;
		end
		bready <= 1'b0;
		if (!dn) begin
			chk("write done", 32'h1, 32'h0);
			summarize();
		end
	endtask : axw
	task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ta, dn;
		ta = 1'b0;
		dn = 1'b0;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!dn && n < 64) begin
			@(negedge clk);
			ta = ta | arready;
			dn = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			n++;
		end
		rready <= 1'b0;
		if (!dn) begin
			chk("read done", 32'h1, 32'h0);
			summarize();
		end
	endtask : axr
	task automatic wf(input int n);
		int c, k;
		c = frames;
		k = 0;
		while (frames < c + n && k < 5000 * n) begin
			@(posedge clk);
			k++;
		end
		if (frames < c + n) begin
			chk("frame done", 32'h1, 32'h0);
			summarize();
		end
	endtask : wf
	// Keystream byte k counted from the reseed point.
	function automatic logic [7:0] ks(input int k);
		logic [6:0] s;
		logic [7:0] b;
		s = `SCR_SEED;
		for (int j = 0; j <= k; j++) begin
			for (int i = 7; i >= 0; i--) begin
				b[i] = s[6];
				s = {s[5:0], s[6] ^ s[5]};
			end
		end
		return b;
	endfunction : ks
	// --------
	// Scenarios
	// --------
	task automatic t_reset;
		axr(`ADDR_E2_VALUE, rd, rs);
		chk("e2 value reset", 32'h0, rd);
		axr(`ADDR_MAPPER_CTRL2, rd, rs);
		chk("mapper reset", 32'h10, rd);
		axr(`ADDR_TX_CTRL, rd, rs);
		chk("ctrl reset", 32'h0, rd);
		chk("sequencer one-hot", 32'h1, $onehot(ost));
		axr(16'h7000, rd, rs);
		chk("unmapped rresp", `AXI_SLVERR, rs);
		chk("unmapped rdata", 32'h0, rd);
		axw(16'h7000, 32'hFFFFFFFF, rs);
		chk("unmapped bresp", `AXI_SLVERR, rs);
		$display("Test reset_values done");
	endtask : t_reset
	task automatic t_regs;
		axw(`ADDR_E2_VALUE, 32'hFFFFFF5A, rs);
		axr(`ADDR_E2_VALUE, rd, rs);
		chk("e2 value rw", 32'h5A, rd);
		axw(`ADDR_TX_CTRL, 32'h0000FFFF, rs);
		axr(`ADDR_TX_CTRL, rd, rs);
		chk("ctrl writable", 32'h3FBF, rd);
		wstrb <= 4'h1;
		axw(`ADDR_TX_CTRL, 32'h0, rs);
		axr(`ADDR_TX_CTRL, rd, rs);
		chk("ctrl byte lanes", 32'h3F00, rd);
		wstrb <= 4'hF;
		axw(`ADDR_TX_CTRL, 32'h0, rs);
		$display("Test registers done");
	endtask : t_regs
	task automatic t_sw;
		axw(`ADDR_E2_VALUE, 32'hA5, rs);
		axw(`ADDR_TX_CTRL, 32'h2000, rs);
		wf(2);
		chk("sw e2 slot", 32'hA5, obuf[`E2_BYTE_INDEX]);
		chk("byte before slot", 32'h75, obuf[`E2_BYTE_INDEX - 1]);
		@(posedge clk);
		ins_req <= 1'b1;
		wf(2);
		chk("request with select one", 32'hA6, obuf[`E2_BYTE_INDEX]);
		@(posedge clk);
		ins_req <= 1'b0;
		$display("Test software_e2 done");
	endtask : t_sw
	task automatic t_pass;
		axw(`ADDR_MAPPER_CTRL2, 32'h0, rs);
		axw(`ADDR_TX_CTRL, 32'h0, rs);
		wf(2);
		chk("slot without accept", 32'h76, obuf[`E2_BYTE_INDEX]);
		$display("Test accept_off done");
	endtask : t_pass
	task automatic t_serial;
		axw(`ADDR_MAPPER_CTRL2, 32'h10, rs);
		wf(3);
		axr(`ADDR_OH_STATUS, rd, rs);
		chk("captured byte", 32'hA6, rd[7:0]);
		chk("serial e2 slot", 32'hA6, obuf[`E2_BYTE_INDEX]);
		c0 = rd[15:8];
		s0 = strobe_rises;
		@(posedge clk);
		far_byte <= 8'h1E;
		wf(3);
		axr(`ADDR_OH_STATUS, rd, rs);
		chk("second capture", 32'h1E, rd[7:0]);
		chk("capture count", 32'h3, rd[15:8] - c0);
		chk("strobe rises", 32'd24, strobe_rises - s0);
		chk("second e2 slot", 32'h1E, obuf[`E2_BYTE_INDEX]);
		$display("Test serial_e2 done");
	endtask : t_serial
	task automatic t_scr;
		axw(`ADDR_TX_CTRL, 32'h0004, rs);
		wf(2);
		for (int k = 0; k < 9; k++)
			chk("unscrambled head", k, obuf[k]);
		for (int k = 0; k < 8; k++)
			chk("scrambled byte", (9 + k) ^ ks(k), obuf[9 + k]);
		axw(`ADDR_TX_CTRL, 32'h0, rs);
		wf(2);
		chk("scrambler off", 32'h09, obuf[9]);
		$display("Test scrambler done");
	endtask : t_scr

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		t_reset();
		t_regs();
		t_sw();
		t_pass();
		t_serial();
		t_scr();
		summarize();
	end
endmodule : tb_e2_tx_block

// ---- logic/e2_tx_block.sv ----
// E2 orderwire source selection, serial overhead capture and frame scrambler.
//------------------------------------------------------------
// Notes on behaviour
// - Source select one takes E2 from software unless insert request is high with accept enable.
// - Software byte copied into each E2 slot.
// - E2 value register, read/write, resets zero.
// - Accept enable lets the serial port supply overhead.
// - Source select zero takes E2 from serial port.
// - Device latches each bit on following rise.
// - Scrambler enable bit turns scrambling on/off.
// - Scrambler polynomial x^7+x^6+1, period 127.
//------------------------------------------------------------
`timescale 1ns/10ps
`include "e2_tx_defs.svh"
module e2_tx_block (
	input  wire logic                     clk,                      // 125 MHz system clock
	input  wire logic                     rst_n,                    // synchronous reset, low
	input  wire logic [15:0]              s_axi_awaddr,             // write address
	input  wire logic                     s_axi_awvalid,            // write address valid
	output logic                          s_axi_awready,            // write address ready
	input  wire logic [31:0]              s_axi_wdata,              // write data
	input  wire logic [3:0]               s_axi_wstrb,              // write byte lanes
	input  wire logic                     s_axi_wvalid,             // write data valid
	output logic                          s_axi_wready,             // write data ready
	output logic [1:0]                    s_axi_bresp,              // write response
	output logic                          s_axi_bvalid,             // write response valid
	input  wire logic                     s_axi_bready,             // write response ready
	input  wire logic [15:0]              s_axi_araddr,             // read address
	input  wire logic                     s_axi_arvalid,            // read address valid
	output logic                          s_axi_arready,            // read address ready
	output logic [31:0]                   s_axi_rdata,              // read data
	output logic [1:0]                    s_axi_rresp,              // read response
	output logic                          s_axi_rvalid,             // read data valid
	input  wire logic                     s_axi_rready,             // read data ready
	input  wire logic [7:0]               tx_in_data,               // outbound frame byte
	input  wire logic                     tx_in_valid,              // byte valid
	input  wire logic                     tx_in_sof,                // first byte of frame
	output logic [7:0]                    tx_out_data,              // processed frame byte
	output logic                          tx_out_valid,             // processed byte valid
	output logic                          tx_out_sof,               // processed frame start
	output logic                          overhead_port_clock,      // port clock, 64 ns
	output logic                          overhead_slot_strobe,     // bit window strobe
	output logic                          overhead_frame_marker,    // frame marker
	input  wire logic                     overhead_serial_in,       // serial E2 bits
	input  wire logic                     overhead_insert_request,  // optional insert request
	output e2_tx_pkg::oh_state_type       oh_state                  // port sequencer state
);
	import e2_tx_pkg::*;
	function automatic logic [14:0] scr_step(input logic [6:0] s);
		logic [6:0] t;
		logic [7:0] k;
		t = s;
		k = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			k[i] = t[6];
			t    = {t[5:0], t[6] ^ t[5]};
		end
		return {t, k};
	endfunction : scr_step
	//------------------------------------------------------------
	// Register bus
	//------------------------------------------------------------
	logic [7:0]  ctrl_b0_q, ctrl_b1_q, e2_sw_q, mapper_q;
	logic [15:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0]  e2_ext_q, cap_count_q;
	wire do_write  = aw_held_q && w_held_q && !bvalid_q;
	wire hit_ctrl  = awaddr_q == `ADDR_TX_CTRL;
	wire hit_e2    = awaddr_q == `ADDR_E2_VALUE;
	wire hit_map   = awaddr_q == `ADDR_MAPPER_CTRL2;
	wire w_mapped  = hit_ctrl || hit_e2 || hit_map;
	wire do_read   = s_axi_arvalid && !rvalid_q;
	wire r_ctrl    = s_axi_araddr == `ADDR_TX_CTRL;
	wire r_e2      = s_axi_araddr == `ADDR_E2_VALUE;
	wire r_map     = s_axi_araddr == `ADDR_MAPPER_CTRL2;
	wire r_stat    = s_axi_araddr == `ADDR_OH_STATUS;
	wire r_mapped  = r_ctrl || r_e2 || r_map || r_stat;
	wire [31:0] rd_mux = r_ctrl ? {16'h0000, ctrl_b1_q, ctrl_b0_q} :
		r_e2 ? {24'h000000, e2_sw_q} : r_map ? {24'h000000, mapper_q} :
		r_stat ? {16'h0000, cap_count_q, e2_ext_q} : 32'h00000000;
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `AXI_OKAY;
			awaddr_q  <= 16'h0000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= w_mapped ? `AXI_OKAY : `AXI_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_b0_q <= `RST_CTRL_B0;
			ctrl_b1_q <= `RST_CTRL_B1;
			e2_sw_q   <= `RST_E2_VALUE;
			mapper_q  <= `RST_MAPPER_CTRL2;
		end else if (do_write) begin
			if (hit_ctrl && wstrb_q[0])
				ctrl_b0_q <= wdata_q[7:0] & `MASK_CTRL_B0;
			if (hit_ctrl && wstrb_q[1])
				ctrl_b1_q <= wdata_q[15:8] & `MASK_CTRL_B1;
			if (hit_e2 && wstrb_q[0])
				e2_sw_q <= wdata_q[7:0];
			if (hit_map && wstrb_q[0])
				mapper_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= `AXI_OKAY;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= r_mapped ? `AXI_OKAY : `AXI_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Overhead port
	//------------------------------------------------------------
	// The port clock is a divided system clock, so the sample and drive moments are known
	// phases of the divider rather than detected edges.
	logic [2:0] div_q;
	logic       pclk_q, sin_m_q, sin_s_q, ins_m_q, ins_s_q;
	logic       frame_pend_q, strobe_q;
	logic [3:0] rise_cnt_q, bit_cnt_q;
	logic [7:0] shift_q;
	oh_state_type state_q;
	wire tick_sample = div_q == `PHASE_SAMPLE;
	wire tick_fall   = div_q == `PHASE_FALL;
	wire in_window   = rise_cnt_q >= `OH_WAIT_PERIODS && bit_cnt_q < `E2_BITS;
	wire capture     = state_q == OH_COLLECT && tick_sample && in_window;
	wire last_bit    = capture && bit_cnt_q == `E2_BITS - 4'd1;
	wire frame_start = tx_in_valid && tx_in_sof;
	assign overhead_port_clock   = pclk_q;
	assign overhead_frame_marker = state_q == OH_MARK;
	assign overhead_slot_strobe  = strobe_q;
	assign oh_state              = state_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_q   <= 3'd0;
			pclk_q  <= 1'b0;
			sin_m_q <= 1'b0;
			sin_s_q <= 1'b0;
			ins_m_q <= 1'b0;
			ins_s_q <= 1'b0;
		end else begin
			div_q   <= div_q + 3'd1;
			pclk_q  <= ~div_q[2];
			sin_m_q <= overhead_serial_in;
			sin_s_q <= sin_m_q;
			ins_m_q <= overhead_insert_request;
			ins_s_q <= ins_m_q;
		end
	end

	// A frame start that lands while the marker is issued is kept, not dropped.
	always_ff @(posedge clk) begin
		if (!rst_n)
			frame_pend_q <= 1'b0;
		else if (frame_start)
			frame_pend_q <= 1'b1;
		else if (state_q == OH_IDLE && tick_fall)
			frame_pend_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q    <= OH_IDLE;
			strobe_q   <= 1'b0;
			rise_cnt_q <= 4'd0;
			bit_cnt_q  <= 4'd0;
		end else begin
			unique case (state_q)
				OH_IDLE: begin
					if (tick_fall && frame_pend_q)
						state_q <= OH_MARK;
				end
				OH_MARK: begin
					rise_cnt_q <= 4'd0;
					bit_cnt_q  <= 4'd0;
					if (tick_fall)
						state_q <= OH_COLLECT;
				end
				OH_COLLECT: begin
					if (tick_sample && !in_window)
						rise_cnt_q <= rise_cnt_q + 4'd1;
					if (capture)
						bit_cnt_q <= bit_cnt_q + 4'd1;
					if (last_bit)
						state_q <= OH_IDLE;
				end
			endcase
			if (tick_fall)
				strobe_q <= state_q == OH_COLLECT && in_window;
			else if (state_q != OH_COLLECT)
				strobe_q <= 1'b0;
		end
	end

	// latch each serial bit on the port rise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_q     <= 8'h00;
			e2_ext_q    <= 8'h00;
			cap_count_q <= 8'h00;
		end else begin
			if (capture)
				shift_q <= {shift_q[6:0], sin_s_q};
			if (last_bit) begin
				e2_ext_q    <= {shift_q[6:0], sin_s_q};
				cap_count_q <= cap_count_q + 8'h01;
			end
		end
	end

	//------------------------------------------------------------
	// Frame datapath
	//------------------------------------------------------------
	logic [11:0] bcnt_q;
	logic [6:0]  scr_q;
	wire [11:0] idx      = tx_in_sof ? 12'd0 : bcnt_q;
	wire        scr_en   = ctrl_b0_q[`BIT_SCR_EN];
	wire        src_sw   = ctrl_b1_q[`BIT_E2_SRC_SEL];
	wire        ext_en   = mapper_q[`BIT_EXT_OH_EN];
	wire        e2_slot  = idx == `E2_BYTE_INDEX;
	wire        use_ext  = ext_en && (!src_sw || ins_s_q);
	wire [6:0]  scr_cur  = idx == `SCR_START_INDEX ? `SCR_SEED : scr_q;
	wire [14:0] scr_nxt  = scr_step(scr_cur);
	wire        scr_here = scr_en && idx >= `SCR_START_INDEX;
	// serial source when select is zero
	// serial source only with accept enable
	wire [7:0]  e2_byte  = use_ext ? e2_ext_q : (src_sw ? e2_sw_q : tx_in_data);
	wire [7:0]  ins_byte = e2_slot ? e2_byte : tx_in_data;
	// scrambling gated by the enable bit
	wire [7:0]  out_byte = scr_here ? ins_byte ^ scr_nxt[7:0] : ins_byte;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bcnt_q       <= 12'd0;
			scr_q        <= `SCR_SEED;
			tx_out_data  <= 8'h00;
			tx_out_valid <= 1'b0;
			tx_out_sof   <= 1'b0;
		end else begin
			tx_out_valid <= tx_in_valid;
			if (tx_in_valid) begin
				if (idx >= `SCR_START_INDEX)
					scr_q <= scr_nxt[14:8];
				if (idx != `FRAME_LAST_INDEX)
					bcnt_q <= idx + 12'd1;
				tx_out_data <= out_byte;
				tx_out_sof  <= tx_in_sof;
			end
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	chk_sw_e2_insert: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && e2_slot && src_sw && !use_ext && !scr_here
		|=> tx_out_data == $past(e2_sw_q)) else $error("software E2 byte not inserted");
	chk_sw_e2_copy: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && e2_slot && src_sw && !ext_en && !scr_en
		|=> tx_out_valid && tx_out_data == $past(e2_sw_q)) else $error("E2 copy wrong");
	chk_e2_reset_val: assert property (@(posedge clk)
		$rose(rst_n) |-> e2_sw_q == 8'h00) else $error("E2 value not zero after reset");
	chk_no_accept_pass: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && e2_slot && !src_sw && !ext_en && !scr_here
		|=> tx_out_data == $past(tx_in_data)) else $error("E2 altered without accept enable");
	chk_ext_e2_insert: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && e2_slot && !src_sw && ext_en && !scr_here
		|=> tx_out_data == $past(e2_ext_q)) else $error("serial E2 byte not inserted");
	chk_bit_latch: assert property (@(posedge clk) disable iff (!rst_n)
		capture |=> shift_q[0] == $past(sin_s_q) && $past(overhead_port_clock, 2)
			&& !$past(overhead_port_clock, 3))
		else $error("serial bit not latched at port rise");
	chk_marker_width: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(overhead_frame_marker) |-> overhead_frame_marker[*8] ##1 !overhead_frame_marker)
		else $error("frame marker not one port period");
	chk_scr_off: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && !scr_en && !e2_slot |=> tx_out_data == $past(tx_in_data))
		else $error("data scrambled while disabled");
	chk_scr_seed: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && !tx_in_sof && bcnt_q == `SCR_START_INDEX && scr_en
		|=> tx_out_data == ($past(tx_in_data) ^ 8'hFE)) else $error("scrambler seed wrong");
	chk_scr_framing: assert property (@(posedge clk) disable iff (!rst_n)
		tx_in_valid && tx_in_sof |=> tx_out_data == $past(tx_in_data))
		else $error("framing byte scrambled");
endmodule : e2_tx_block

// ---- logic/e2_tx_defs.svh ----
// Register map, field positions, reset values and timing counts of the E2 transmit block.
`ifndef E2_TX_DEFS_SVH
`define E2_TX_DEFS_SVH
// Register indices as printed; byte address is four times the index.
`define IDX_TX_CTRL        16'h1902
`define IDX_E2_VALUE       16'h1947
`define IDX_MAPPER_CTRL2   16'h1960
`define IDX_OH_STATUS      16'h1961
`define ADDR_TX_CTRL       16'h6408
`define ADDR_E2_VALUE      16'h651C
`define ADDR_MAPPER_CTRL2  16'h6580
`define ADDR_OH_STATUS     16'h6584
// Field positions.
`define BIT_SCR_EN         2
`define BIT_E2_SRC_SEL     5
`define BIT_EXT_OH_EN      4
// Reset values.
`define RST_CTRL_B0        8'h00
`define RST_CTRL_B1        8'h00
`define RST_E2_VALUE       8'h00
`define RST_MAPPER_CTRL2   8'h10
// Writable masks: reserved bits stay zero.
`define MASK_CTRL_B0       8'hBF
`define MASK_CTRL_B1       8'h3F
// Frame positions in bytes from the frame start.
`define E2_BYTE_INDEX      12'd2166
`define SCR_START_INDEX    12'd9
`define FRAME_LAST_INDEX   12'd4095
// Overhead port timing.
`define PORT_CLK_NS        64
`define SYS_CLK_NS         8
`define PORT_DIV           (`PORT_CLK_NS / `SYS_CLK_NS)
`define PHASE_RISE         3'd0
`define PHASE_SAMPLE       3'd2
`define PHASE_FALL         3'd4
`define OH_WAIT_PERIODS    4'd3
`define E2_BITS            4'd8
`define SCR_SEED           7'h7F
`define AXI_OKAY           2'h0
`define AXI_SLVERR         2'h2
`endif

// ---- logic/e2_tx_pkg.sv ----
// Types shared by the E2 transmit block.
package e2_tx_pkg;
	typedef enum logic [2:0] {
		OH_IDLE    = 3'b001,
		OH_MARK    = 3'b010,
		OH_COLLECT = 3'b100
	} oh_state_type;
endpackage : e2_tx_pkg
